// file: design/ptm_period_timer.sv
// What this block does
// - 8-bit read/write counter, reset clears it
// - counter advances on prescaled instruction clock
// - prescale 1:1, 1:4, 1:16 from bits 1:0
// - counter wraps to zero after equalling period
// - 8-bit period register, resets to ffh
// - 4-bit postscaler sets match flag bit 1
// - postscale ratio is match field plus one
// - run bit 2 gates counting
// - counter or control write clears both dividers
// - control write keeps counter value
// - pre-postscaler match pulse goes to serial port
// - control bit 7 reads zero
// - match pulse is shared pwm time base
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ptm_period_timer (
  input  wire logic       sys_clk,        // 125 mhz oscillator clock
  input  wire logic       nrst,           // synchronous reset, active low
  input  wire logic [7:0] reg_addr,       // register byte address
  input  wire logic [7:0] reg_wdata,      // write data
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  output logic      [7:0] reg_rdata,      // read data, cycle after strobe
  output logic            irq,            // level interrupt
  output logic            ssp_match,      // match pulse to serial port
  output logic            pwm_timebase    // match pulse for pwm units
);

  // ************************************************************
  // register bus decode
  // ************************************************************
  ptm_pkg::ptm_bus_s bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire wr_flags  = bus.wr && (bus.addr == ptm_pkg::OFS_EVENT_FLAGS);
  wire wr_clear  = bus.wr && (bus.addr == ptm_pkg::OFS_EVENT_CLEAR);
  wire wr_count  = bus.wr && (bus.addr == ptm_pkg::OFS_COUNTER_VALUE);
  wire wr_ctrl   = bus.wr && (bus.addr == ptm_pkg::OFS_TIMER_CONTROL);
  wire wr_enable = bus.wr && (bus.addr == ptm_pkg::OFS_EVENT_ENABLES);
  wire wr_period = bus.wr && (bus.addr == ptm_pkg::OFS_PERIOD_LIMIT);

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]        count_r;
  logic [7:0]        period_r;
  ptm_pkg::ptm_ctrl_s ctrl_r;
  logic [7:0]        flags_r;
  logic [7:0]        enables_r;
  logic [1:0]        phase_r;
  logic [3:0]        pre_r;
  logic [3:0]        post_r;
  logic [7:0]        rdata_r;
  logic              irq_r;
  logic              match_r;

  // ************************************************************
  // instruction clock and prescaler
  // ************************************************************
  // phase counter free-runs so the instruction clock is not
  // retimed by register writes, only the prescaler and postscaler are cleared
  wire insn_tick = (phase_r == ptm_pkg::INSN_PHASE_LAST);
  wire div_clear = wr_count || wr_ctrl;

  // upper select bit alone picks 1:16
  wire [3:0] pre_last = ctrl_r.input_divider_select[1] ? ptm_pkg::PRE_LAST_DIV16
                      : ctrl_r.input_divider_select[0] ? ptm_pkg::PRE_LAST_DIV4
                      : 4'h0;
  wire pre_tick  = ctrl_r.counter_run && insn_tick && !div_clear
                   && (pre_r == pre_last);
  wire [3:0] pre_nxt = div_clear ? 4'h0
                     : (ctrl_r.counter_run && insn_tick)
                       ? ((pre_r == pre_last) ? 4'h0 : pre_r + 4'h1)
                       : pre_r;

  // ************************************************************
  // counter, period compare and postscaler
  // ************************************************************
  wire       at_period = (count_r == period_r);
  wire       match     = pre_tick && at_period;
  wire [7:0] count_nxt = wr_count ? bus.wdata
                       : match ? 8'h00
                       : pre_tick ? count_r + 8'h01 : count_r;

  wire       post_done = match && (post_r == ctrl_r.match_divider_select);
  wire [3:0] post_nxt  = div_clear ? 4'h0
                       : post_done ? 4'h0
                       : match ? post_r + 4'h1 : post_r;

  // set wins over a same-cycle clear; software must clear the flag
  wire [7:0] flag_set  = {6'h00, post_done, 1'b0};
  wire [7:0] flags_nxt = (wr_flags ? bus.wdata
                          : wr_clear ? (flags_r & ~bus.wdata) : flags_r)
                         | flag_set;

  // ************************************************************
  // read mux
  // ************************************************************
  wire [7:0] ctrl_rd = {1'b0, ctrl_r};
  wire [7:0] rd_mux  = (bus.addr == ptm_pkg::OFS_EVENT_FLAGS)   ? flags_r
                     : (bus.addr == ptm_pkg::OFS_COUNTER_VALUE) ? count_r
                     : (bus.addr == ptm_pkg::OFS_TIMER_CONTROL) ? ctrl_rd
                     : (bus.addr == ptm_pkg::OFS_EVENT_ENABLES) ? enables_r
                     : (bus.addr == ptm_pkg::OFS_PERIOD_LIMIT)  ? period_r
                     : 8'h00;
  wire [7:0] rdata_nxt = bus.rd ? rd_mux : 8'h00;
  wire       irq_nxt   = |(flags_nxt & enables_r);

  // ************************************************************
  // registers
  // ************************************************************
  // counter: a write wins over a wrap, a wrap over a step
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_r <= ptm_pkg::RST_COUNTER_VALUE;
    end else begin
      count_r <= count_nxt;
    end
  end

  // control: bit 7 is never stored, so it cannot read back as one
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_r <= ptm_pkg::RST_TIMER_CONTROL[6:0];
    end else if (wr_ctrl) begin
      ctrl_r <= bus.wdata[6:0];
    end
  end

  // period limit: every reset brings it back to ffh
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      period_r <= ptm_pkg::RST_PERIOD_LIMIT;
    end else if (wr_period) begin
      period_r <= bus.wdata;
    end
  end

  // event flags: hardware only ever sets, software clears
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flags_r <= ptm_pkg::RST_EVENT_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // event enables: plain storage, gates the interrupt only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      enables_r <= ptm_pkg::RST_EVENT_ENABLES;
    end else if (wr_enable) begin
      enables_r <= bus.wdata;
    end
  end

  // instruction phase: free-running so writes never retime the
  // instruction clock; only a reset realigns it
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // prescaler count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pre_r <= 4'h0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // postscaler count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      post_r <= 4'h0;
    end else begin
      post_r <= post_nxt;
    end
  end

  // read data: zero outside the cycle after a read strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // interrupt level, registered so the pin never glitches
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // registered match pulse; costs one cycle of latency but keeps
  // the serial port and pwm ticks free of decode glitches
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match;
    end
  end

  assign reg_rdata    = rdata_r;
  assign irq          = irq_r;
  assign ssp_match    = match_r;
  assign pwm_timebase = match_r;

  // ************************************************************
  // checks
  // ************************************************************
  chk_wrap_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    match && !wr_count |=> count_r == 8'h00)
    else $error("counter did not wrap after period match");

  chk_run_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ctrl_r.counter_run && !wr_count |=> count_r == $past(count_r))
    else $error("counter moved while stopped");

  chk_ctrl_keeps: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_ctrl |=> count_r == $past(count_r) && pre_r == 4'h0 && post_r == 4'h0)
    else $error("control write disturbed counter or dividers");

  chk_count_wr: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_count |=> count_r == $past(bus.wdata) && pre_r == 4'h0 && post_r == 4'h0)
    else $error("counter write mishandled");

  chk_bit7_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(bus.rd) && $past(bus.addr) == ptm_pkg::OFS_TIMER_CONTROL |-> !reg_rdata[7])
    else $error("control bit 7 read as one");

  chk_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    post_done |=> flags_r[ptm_pkg::MATCH_FLAG_BIT] ##1 irq || !enables_r[1])
    else $error("match flag not set after postscale");

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    flags_r[1] && !wr_flags && !wr_clear |=> flags_r[1])
    else $error("match flag cleared by hardware");

  chk_div1_fast: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctrl_r == 7'h04 && insn_tick && !bus.wr |=> pre_r == 4'h0)
    else $error("1:1 prescale used a divider count");

  chk_ssp_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    match |=> ssp_match ##1 !ssp_match)
    else $error("serial port match pulse wrong");

  // ************************************************************
  // reset checks
  // ************************************************************
  // reset is synchronous, so each check looks one edge later
  chk_reset_count: assert property (@(posedge sys_clk)
    !nrst
    |=> count_r == 8'h00)
    else $error("counter not zero after reset");

  // control must come back off with 1:1 dividers
  chk_reset_ctrl: assert property (@(posedge sys_clk)
    !nrst
    |=> ctrl_r == 7'h00)
    else $error("control not zero after reset");

  // period limit starts at its full range
  chk_reset_period: assert property (@(posedge sys_clk)
    !nrst
    |=> period_r == 8'hff)
    else $error("period limit not ffh after reset");

  // both divider counts start from zero
  chk_reset_divs: assert property (@(posedge sys_clk)
    !nrst
    |=> pre_r == 4'h0 && post_r == 4'h0)
    else $error("divider counts not zero after reset");

  // ************************************************************
  // counter checks
  // ************************************************************
  // the counter only moves on an instruction tick or a write
  chk_tick_only: assert property (@(posedge sys_clk) disable iff (!nrst)
    !insn_tick && !wr_count
    |=> count_r == $past(count_r))
    else $error("counter moved between instruction ticks");

  // below the period an increment adds exactly one
  chk_step_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    pre_tick && !at_period
    |=> count_r == $past(count_r) + 8'h01)
    else $error("counter did not step by one");

  // in 1:4 mode the prescale count never passes three
  chk_pre_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctrl_r.input_divider_select == 2'h1
    |-> pre_r <= ptm_pkg::PRE_LAST_DIV4)
    else $error("prescale count beyond 1:4 range");

  // a stopped timer never produces a match
  chk_match_stops: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ctrl_r.counter_run
    |-> !match)
    else $error("match while timer stopped");

  // a period write lands on the next cycle
  chk_wr_period: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_period
    |=> period_r == $past(bus.wdata))
    else $error("period limit write lost");

  // nothing but a write changes the period limit
  chk_period_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !wr_period
    |=> period_r == $past(period_r))
    else $error("period limit changed without a write");

  // a counter read returns the value at the strobe
  chk_rd_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(bus.rd) && $past(bus.addr) == ptm_pkg::OFS_COUNTER_VALUE
    |-> reg_rdata == $past(count_r))
    else $error("counter read returned wrong value");

  // ************************************************************
  // postscaler and flag checks
  // ************************************************************
  // the postscale count stays inside the selected ratio
  chk_post_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1
    |-> post_r <= ctrl_r.match_divider_select)
    else $error("postscale count beyond selected ratio");

  // a completed postscale restarts the count
  chk_post_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    post_done
    |=> post_r == 4'h0)
    else $error("postscale count not restarted");

  // the flag only rises from a postscale or a direct write
  chk_flag_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(flags_r[1])
    |-> $past(post_done) || $past(wr_flags))
    else $error("match flag rose without cause");

  // a clear without a same-cycle set drops the flag
  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_clear && bus.wdata[1] && !post_done
    |=> !flags_r[1])
    else $error("match flag not cleared by software");

  // an enabled, set flag holds the interrupt up
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    flags_r[1] && enables_r[1] && $stable(enables_r)
    |-> irq)
    else $error("interrupt low while enabled flag set");

  // ************************************************************
  // match output checks
  // ************************************************************
  // the serial port tick follows a match and nothing else
  chk_ssp_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
    ssp_match
    |-> $past(match))
    else $error("serial port tick without a match");

  // all pwm units see the very same tick as the serial port
  chk_pwm_same: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1
    |-> pwm_timebase == ssp_match)
    else $error("pwm time base differs from match tick");

endmodule

`default_nettype wire

// file: design/ptm_pkg.sv
package ptm_pkg;

  // ************************************************************
  // register offsets (byte addresses on the plain port)
  // ************************************************************
  localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h0c;
  localparam logic [7:0] OFS_COUNTER_VALUE = 8'h11;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] OFS_EVENT_ENABLES = 8'h8c;
  localparam logic [7:0] OFS_PERIOD_LIMIT  = 8'h92;
  localparam logic [7:0] OFS_EVENT_CLEAR   = 8'h0d;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_EVENT_FLAGS   = 8'h00;
  localparam logic [7:0] RST_COUNTER_VALUE = 8'h00;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_EVENT_ENABLES = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT  = 8'hff;
  localparam int         MATCH_FLAG_BIT    = 1;
  localparam logic [7:0] CTRL_IMPL_MASK    = 8'h7f;

  // ************************************************************
  // timing: instruction clock is the oscillator divided by four
  // ************************************************************
  localparam int         INSN_CLK_DIV      = 4;
  localparam logic [1:0] INSN_PHASE_LAST   = 2'h3;
  localparam logic [3:0] PRE_LAST_DIV4     = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16    = 4'hf;

  typedef struct packed {
    logic [3:0] match_divider_select;
    logic       counter_run;
    logic [1:0] input_divider_select;
  } ptm_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ptm_bus_s;

endpackage

// file: tb/ptm_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// match pulse consumer
// ********************
// stands in for the serial port and the pwm units, which share one tick
module ptm_far_side (
  input  wire logic        sys_clk,      // oscillator clock
  input  wire logic        nrst,         // sync reset, active low
  input  wire logic        ssp_match,    // shift clock source
  input  wire logic        pwm_timebase, // pwm period tick
  output logic      [15:0] n_pulse,      // pulses seen
  output logic      [15:0] gap,          // cycles between last two pulses
  output logic             skew          // sticky: the two ticks disagreed
);
  logic [15:0] run_r;
  // gap is the pwm period; a lone first pulse gives a meaningless gap
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      run_r   <= 16'h0001;
      n_pulse <= 16'h0000;
      gap     <= 16'h0000;
      skew    <= 1'b0;
    end else begin
      run_r <= ssp_match ? 16'h0001 : run_r + 16'h0001;
      if (ssp_match) begin
        n_pulse <= n_pulse + 16'h0001;
        gap     <= run_r;
      end
      if (ssp_match != pwm_timebase)
        skew <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb/ptm_period_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_period_timer_tb_top;
  logic        sys_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata, v;
  logic        irq, ssp_match, pwm_timebase, skew;
  logic [15:0] n_pulse, gap;
  int          n_errors  = 0;
  int          n_checks  = 0;
  always #4 sys_clk = ~sys_clk;
  ptm_period_timer dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .ssp_match(ssp_match), .pwm_timebase(pwm_timebase));
  ptm_far_side far (.sys_clk(sys_clk), .nrst(nrst), .ssp_match(ssp_match),
    .pwm_timebase(pwm_timebase), .n_pulse(n_pulse), .gap(gap), .skew(skew));
  // ********************
  // bus cycles and compare
  // ********************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pulses(input logic [15:0] k);
    logic [15:0] n0;
    n0 = n_pulse;
    for (int i = 0; i < 2000 && n_pulse != n0 + k; i++) @(posedge sys_clk);
    chk("pulses", n0 + k, n_pulse);
    repeat (3) @(posedge sys_clk);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rd(8'h11);
    chk("counter", 8'h00, v);
    rd(8'h12);
    chk("control", 8'h00, v);
    rd(8'h92);
    chk("period", 8'hff, v);
    rd(8'h55);
    chk("unmapped", 8'h00, v);
    wr(8'h92, 8'h5a);
    rd(8'h92);
    chk("period rw", 8'h5a, v);
  endtask
  task automatic t_hold();
    wr(8'h11, 8'h05);
    repeat (20) @(posedge sys_clk);
    rd(8'h11);
    chk("stopped", 8'h05, v);
    wr(8'h12, 8'hf8);
    rd(8'h12);
    chk("bit7", 8'h78, v);
    rd(8'h11);
    chk("kept", 8'h05, v);
  endtask
  // period 1 gives two prescaled ticks per match, one step and one wrap; codes 10 and 11 must agree
  task automatic t_ratio();
    logic [15:0] eg [4] = '{16'd8, 16'd32, 16'd128, 16'd128};
    wr(8'h92, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(8'h12, 8'h04 | 8'(c));
      pulses(16'd3);
      chk("gap", eg[c], gap);
    end
  endtask
  task automatic t_post();
    wr(8'h12, 8'h00);
    wr(8'h0d, 8'h02);
    wr(8'h11, 8'h00);
    wr(8'h8c, 8'h02);
    wr(8'h12, 8'h14);
    pulses(16'd2);
    rd(8'h0c);
    chk("flag early", 8'h00, v);
    pulses(16'd1);
    rd(8'h0c);
    chk("flag", 8'h02, v);
    chk("irq", 1'b1, irq);
    wr(8'h12, 8'h10);
    repeat (30) @(posedge sys_clk);
    rd(8'h0c);
    chk("sticky", 8'h02, v);
    wr(8'h8c, 8'h00);
    @(posedge sys_clk);
    #1 chk("masked", 1'b0, irq);
    wr(8'h0d, 8'h02);
    rd(8'h0c);
    chk("cleared", 8'h00, v);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_hold();
    t_ratio();
    t_post();
    chk("skew", 1'b0, skew);
    summarize();
  end
  // watchdog: the whole run needs about two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
endmodule
`default_nettype wire
